// ---- hw/rlig_defs.svh ----
// Register offsets, field positions, reset values and timing counts of the ramp, limit and interlock gate.
`ifndef RLIG_DEFS_SVH
`define RLIG_DEFS_SVH
`define RLIG_A_CTRL 8'h00
`define RLIG_A_STATUS 8'h04
`define RLIG_A_IRQ_STAT 8'h08
`define RLIG_A_IRQ_MASK 8'h0C
`define RLIG_A_TARGET 8'h10
`define RLIG_A_ACC_TIME 8'h14
`define RLIG_A_DEC_TIME 8'h18
`define RLIG_A_CMD_REF 8'h1C
`define RLIG_A_FREQ_LIM 8'h20
`define RLIG_A_SPEED_LIM 8'h24
`define RLIG_A_TORQ_LIM 8'h28
`define RLIG_A_CUR_MAX 8'h2C
`define RLIG_A_ILK_CFG 8'h30
`define RLIG_A_REF_OUT 8'h34
`define RLIG_C_RUN 0
`define RLIG_C_VECTOR 1
`define RLIG_C_STOP_COAST 2
`define RLIG_C_ILK_COAST 3
`define RLIG_C_WARN_RUN 4
`define RLIG_I_ILK_TRIP 0
`define RLIG_I_CUR_LIM 1
`define RLIG_I_STOPPED 2
`define RLIG_RST_CTRL 5'h00
`define RLIG_RST_TARGET 16'h1388
`define RLIG_RST_TIME 17'h0_7530
`define RLIG_RST_LIM 32'hFFFF_0000
`define RLIG_RST_CUR_MAX 16'h0000
`define RLIG_RST_ILK_CFG 32'h0000_0000
`define RLIG_CLK_KHZ 200000
`define RLIG_TICK_MS 1
`define RLIG_TICK_CYC (`RLIG_TICK_MS * `RLIG_CLK_KHZ)
`define RLIG_BLINK_MS 250
`define RLIG_BLINK_TICKS (`RLIG_BLINK_MS / `RLIG_TICK_MS)
`define RLIG_NUM_INPUTS 6
`endif

// ---- hw/rlig_pkg.sv ----
// Types shared by the ramp, limit and interlock gate.
package rlig_pkg;
  typedef enum logic [1:0] {
    RLIG_IDLE = 2'b00,
    RLIG_RUN = 2'b01,
    RLIG_DECEL = 2'b10
  } rlig_state_e;
  typedef logic [15:0] rlig_ref_t;
endpackage

// ---- hw/rlig_core.sv ----
// Motor reference ramp, limit clamp, current limit and four-channel interlock gate.
// What this block does
// - Acceleration ramps reference from zero to target frequency over acceleration time.
// - Deceleration ramps reference from target frequency to zero over deceleration time.
// - Every reference change during operation is rate limited by the ramp.
// - Coast stop drops control at once when run is withdrawn.
// - Ramp stop follows the deceleration ramp to standstill after run withdrawn.
// - Reference is clamped between configurable minimum and maximum limits.
// - Scalar mode uses frequency limits, vector mode uses speed limits.
// - Current above the maximum setting is not sustained, independent of overload.
// - Motor does not run while any enabled interlock is unsatisfied.
// - Each interlock takes its level from one of six logic inputs.
// - Polarity high needs logic one, low needs logic zero, else unsatisfied.
// - Unsatisfied interlock under warning condition flashes indicator and warning output.
// - One shared setting warns always, or only while run is commanded.
// - Interlock going unsatisfied stops the motor by coast or ramp, as configured.
// - Each interlock has a satisfied flag readable over the register port.
// - Four independent interlock channels, each with source, polarity and enable setting.
`timescale 1ns/1ps
`default_nettype none
`include "rlig_defs.svh"
module rlig_core #(
  parameter int unsigned TICK_CYC = `RLIG_TICK_CYC
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Feedback and torque command
  input wire rlig_pkg::rlig_ref_t torque_ref_i,
  input wire logic [15:0] current_i,
  // Interlock switches
  input wire logic [`RLIG_NUM_INPUTS-1:0] logic_input_i,
  // Motor output stage
  output logic drive_en_o,
  output rlig_pkg::rlig_ref_t ref_o,
  output rlig_pkg::rlig_ref_t torque_ref_o,
  output logic cur_lim_o,
  output rlig_pkg::rlig_state_e state_o,
  // Indicators
  output logic [3:0] ilk_sat_o,
  output logic warn_o,
  output logic led_o,
  output logic irq_o
);
  import rlig_pkg::*;

  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [31:0] lim);
    logic [15:0] lo;
    logic [15:0] hi;
    lo = lim[15:0];
    hi = lim[31:16];
    if (v < lo) begin
      clamp = lo;
    end else if (v > hi) begin
      clamp = hi;
    end else begin
      clamp = v;
    end
  endfunction

  // Software registers.
  logic [4:0] ctrl;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [15:0] target;
  logic [16:0] acc_time;
  logic [16:0] dec_time;
  logic [15:0] cmd_ref;
  logic [31:0] freq_lim;
  logic [31:0] speed_lim;
  logic [31:0] torq_lim;
  logic [15:0] cur_max;
  logic [31:0] ilk_cfg;

  // Block state.
  rlig_state_e state;
  rlig_state_e next_state;
  logic coast_now;
  logic [31:0] ref_q;
  logic [31:0] next_ref;
  logic [31:0] step_acc;
  logic [31:0] step_dec;
  logic [17:0] tick_cnt;
  logic tick;
  logic [7:0] blink_cnt;
  logic blink;
  logic [3:0] ilk_sat;
  logic [3:0] ilk_sat_q;
  logic cur_over_q;

  // Address decode.
  wire wr_ctrl = reg_wr_i && (reg_addr_i == `RLIG_A_CTRL);
  wire wr_istat = reg_wr_i && (reg_addr_i == `RLIG_A_IRQ_STAT);
  wire wr_imask = reg_wr_i && (reg_addr_i == `RLIG_A_IRQ_MASK);
  wire wr_target = reg_wr_i && (reg_addr_i == `RLIG_A_TARGET);
  wire wr_acc = reg_wr_i && (reg_addr_i == `RLIG_A_ACC_TIME);
  wire wr_dec = reg_wr_i && (reg_addr_i == `RLIG_A_DEC_TIME);
  wire wr_cmd = reg_wr_i && (reg_addr_i == `RLIG_A_CMD_REF);
  wire wr_flim = reg_wr_i && (reg_addr_i == `RLIG_A_FREQ_LIM);
  wire wr_slim = reg_wr_i && (reg_addr_i == `RLIG_A_SPEED_LIM);
  wire wr_tlim = reg_wr_i && (reg_addr_i == `RLIG_A_TORQ_LIM);
  wire wr_cmax = reg_wr_i && (reg_addr_i == `RLIG_A_CUR_MAX);
  wire wr_ilk = reg_wr_i && (reg_addr_i == `RLIG_A_ILK_CFG);

  wire run_cmd = ctrl[`RLIG_C_RUN];
  wire vector_mode = ctrl[`RLIG_C_VECTOR];
  wire stop_coast = ctrl[`RLIG_C_STOP_COAST];
  wire ilk_coast = ctrl[`RLIG_C_ILK_COAST];
  wire warn_run_only = ctrl[`RLIG_C_WARN_RUN];

  // Interlock channels; a disabled channel always counts as satisfied.
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ilk
      wire [4:0] cfg = ilk_cfg[8*g +: 5];
      wire src_ok = cfg[2:0] < 3'h6;
      wire lvl = src_ok ? logic_input_i[cfg[2:0]] : 1'b0;
      assign ilk_sat[g] = !cfg[4] || (src_ok && (lvl == cfg[3]));
    end
  endgenerate

  wire any_unsat = ~&ilk_sat;
  wire ilk_fall = |(ilk_sat_q & ~ilk_sat);
  wire warn_act = any_unsat && (!warn_run_only || run_cmd);

  // Limit pair follows the motor control mode.
  wire [31:0] ref_lim = vector_mode ? speed_lim : freq_lim;
  wire cur_over = (cur_max != 16'h0000) && (current_i > cur_max);
  wire [15:0] ref_clamped = clamp(cmd_ref, ref_lim);

  // Over current pulls the reference down to the minimum at the deceleration rate.
  wire [15:0] dest = (state == RLIG_RUN) ? (cur_over ? ref_lim[15:0] : ref_clamped) : 16'h0000;
  wire [31:0] dest_q = {dest, 16'h0000};
  wire ramp_up = dest_q > ref_q;
  wire [32:0] ref_up = {1'b0, ref_q} + {1'b0, step_acc};
  wire [31:0] ref_gap = ref_q - dest_q;
  wire [31:0] ref_down = ref_q - step_dec;

  // Slope divider: step is target times 65536 over the ramp time in ticks.
  logic [5:0] div_cnt;
  logic div_sel;
  logic [31:0] div_q;
  logic [16:0] div_r;
  logic [16:0] div_d;
  wire [17:0] div_sh = {div_r, div_q[31]};
  wire div_ge = div_sh >= {1'b0, div_d};
  wire [17:0] div_sub = div_sh - {1'b0, div_d};
  wire [31:0] next_div_q = {div_q[30:0], div_ge};
  wire [16:0] next_div_r = div_ge ? div_sub[16:0] : div_sh[16:0];
  wire div_done = div_cnt == 6'h20;
  wire [31:0] div_res = (div_d == 17'h0_0000) ? 32'hFFFF_FFFF : next_div_q;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_cnt <= 6'h00;
      div_sel <= 1'b0;
      div_q <= 32'h0000_0000;
      div_r <= 17'h0_0000;
      div_d <= 17'h0_0000;
    end else if (div_cnt == 6'h00) begin
      div_q <= {target, 16'h0000};
      div_r <= 17'h0_0000;
      div_d <= div_sel ? dec_time : acc_time;
      div_cnt <= 6'h01;
    end else begin
      div_q <= next_div_q;
      div_r <= next_div_r;
      div_cnt <= div_done ? 6'h00 : div_cnt + 6'h01;
      if (div_done) begin
        div_sel <= ~div_sel;
      end
    end
  end

  // A slope is recomputed every 66 cycles, so a new ramp time acts almost at once.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      step_acc <= 32'h0000_0000;
      step_dec <= 32'h0000_0000;
    end else if (div_done && !div_sel) begin
      step_acc <= div_res;
    end else if (div_done && div_sel) begin
      step_dec <= div_res;
    end
  end

  // Control tick and indicator blink.
  wire tick_wrap = tick_cnt == 18'(TICK_CYC - 1);
  wire blink_wrap = blink_cnt == 8'(`RLIG_BLINK_TICKS - 1);

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_cnt <= 18'h0_0000;
      tick <= 1'b0;
    end else begin
      tick_cnt <= tick_wrap ? 18'h0_0000 : tick_cnt + 18'h0_0001;
      tick <= tick_wrap;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      blink_cnt <= 8'h00;
      blink <= 1'b0;
    end else if (tick) begin
      blink_cnt <= blink_wrap ? 8'h00 : blink_cnt + 8'h01;
      blink <= blink ^ blink_wrap;
    end
  end

  // Sequencer.
  always_comb begin
    next_state = state;
    coast_now = 1'b0;
    unique case (state)
      RLIG_IDLE: begin
        if (run_cmd && !any_unsat) begin
          next_state = RLIG_RUN;
        end
      end
      RLIG_RUN: begin
        if (any_unsat) begin
          next_state = ilk_coast ? RLIG_IDLE : RLIG_DECEL;
          coast_now = ilk_coast;
        end else if (!run_cmd) begin
          next_state = stop_coast ? RLIG_IDLE : RLIG_DECEL;
          coast_now = stop_coast;
        end
      end
      RLIG_DECEL: begin
        if (run_cmd && !any_unsat) begin
          next_state = RLIG_RUN;
        end else if (ref_q == 32'h0000_0000) begin
          next_state = RLIG_IDLE;
        end
      end
      default: begin
        next_state = RLIG_IDLE;
      end
    endcase
  end

  // Reference ramp; the same slopes govern starts, ramp stops and every change in between.
  always_comb begin
    next_ref = ref_q;
    if (state == RLIG_IDLE || coast_now) begin
      next_ref = 32'h0000_0000;
    end else if (tick) begin
      if (ramp_up) begin
        next_ref = (ref_up >= {1'b0, dest_q}) ? dest_q : ref_up[31:0];
      end else begin
        next_ref = (ref_gap <= step_dec) ? dest_q : ref_down;
      end
    end
  end

  wire ev_stop = (state != RLIG_IDLE) && (next_state == RLIG_IDLE);
  wire ev_cur = cur_over && !cur_over_q;
  wire [2:0] irq_ev = {ev_stop, ev_cur, ilk_fall};
  wire [2:0] irq_clr = wr_istat ? reg_wdata_i[2:0] : 3'h0;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= RLIG_IDLE;
      ref_q <= 32'h0000_0000;
      drive_en_o <= 1'b0;
      ilk_sat_q <= 4'hF;
      cur_over_q <= 1'b0;
      torque_ref_o <= 16'h0000;
    end else begin
      state <= next_state;
      ref_q <= next_ref;
      drive_en_o <= next_state != RLIG_IDLE;
      ilk_sat_q <= ilk_sat;
      cur_over_q <= cur_over;
      torque_ref_o <= clamp(torque_ref_i, torq_lim);
    end
  end

  // Event flags: a new event in the clearing cycle survives the clear.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_stat <= 3'h0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl <= `RLIG_RST_CTRL;
      irq_mask <= 3'h0;
      target <= `RLIG_RST_TARGET;
      acc_time <= `RLIG_RST_TIME;
      dec_time <= `RLIG_RST_TIME;
      cmd_ref <= 16'h0000;
      freq_lim <= `RLIG_RST_LIM;
      speed_lim <= `RLIG_RST_LIM;
      torq_lim <= `RLIG_RST_LIM;
      cur_max <= `RLIG_RST_CUR_MAX;
      ilk_cfg <= `RLIG_RST_ILK_CFG;
    end else begin
      if (wr_ctrl) begin
        ctrl <= reg_wdata_i[4:0];
      end
      if (wr_imask) begin
        irq_mask <= reg_wdata_i[2:0];
      end
      if (wr_target) begin
        target <= reg_wdata_i[15:0];
      end
      if (wr_acc) begin
        acc_time <= reg_wdata_i[16:0];
      end
      if (wr_dec) begin
        dec_time <= reg_wdata_i[16:0];
      end
      if (wr_cmd) begin
        cmd_ref <= reg_wdata_i[15:0];
      end
      if (wr_flim) begin
        freq_lim <= reg_wdata_i;
      end
      if (wr_slim) begin
        speed_lim <= reg_wdata_i;
      end
      if (wr_tlim) begin
        torq_lim <= reg_wdata_i;
      end
      if (wr_cmax) begin
        cur_max <= reg_wdata_i[15:0];
      end
      if (wr_ilk) begin
        ilk_cfg <= reg_wdata_i & 32'h1F1F_1F1F;
      end
    end
  end

  // Read mux; unmapped offsets read as zero.
  wire [31:0] status_word = {26'h000_0000, cur_over_q, warn_act, ilk_sat};
  logic [31:0] rd_mux;
  always_comb begin
    unique case (reg_addr_i)
      `RLIG_A_CTRL: rd_mux = {27'h000_0000, ctrl};
      `RLIG_A_STATUS: rd_mux = status_word;
      `RLIG_A_IRQ_STAT: rd_mux = {29'h0000_0000, irq_stat};
      `RLIG_A_IRQ_MASK: rd_mux = {29'h0000_0000, irq_mask};
      `RLIG_A_TARGET: rd_mux = {16'h0000, target};
      `RLIG_A_ACC_TIME: rd_mux = {15'h0000, acc_time};
      `RLIG_A_DEC_TIME: rd_mux = {15'h0000, dec_time};
      `RLIG_A_CMD_REF: rd_mux = {16'h0000, cmd_ref};
      `RLIG_A_FREQ_LIM: rd_mux = freq_lim;
      `RLIG_A_SPEED_LIM: rd_mux = speed_lim;
      `RLIG_A_TORQ_LIM: rd_mux = torq_lim;
      `RLIG_A_CUR_MAX: rd_mux = {16'h0000, cur_max};
      `RLIG_A_ILK_CFG: rd_mux = ilk_cfg;
      `RLIG_A_REF_OUT: rd_mux = {14'h0000, state, ref_q[31:16]};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0000_0000;
    end
  end

  // Outputs.
  assign ref_o = ref_q[31:16];
  assign state_o = state;
  assign cur_lim_o = cur_over_q;
  assign ilk_sat_o = ilk_sat_q;
  assign warn_o = warn_act && blink;
  assign led_o = warn_act ? blink : 1'b1;
  assign irq_o = |(irq_stat & irq_mask);
endmodule // rlig_core
`default_nettype wire

// ---- test/rlig_core_properties.sv ----
// Port-level assertions for the ramp, limit and interlock gate, bound into its core.
`timescale 1ns/1ps
`default_nettype none
module rlig_checker
  import rlig_pkg::*;
#(
  parameter int unsigned TICK_CYC = 20
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // Motor side and indicators
  input wire logic drive_en_o,
  input wire rlig_pkg::rlig_ref_t ref_o,
  input wire rlig_pkg::rlig_state_e state_o,
  input wire logic [3:0] ilk_sat_o,
  input wire logic warn_o,
  input wire logic led_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Changes in idle are coast drops, so they do not restart the tick spacing.
  rlig_ref_t prev_ref;
  logic [31:0] since_step;
  logic stepped;
  assign stepped = (state_o != RLIG_IDLE) && (ref_o != prev_ref);
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prev_ref <= '0;
      since_step <= TICK_CYC;
    end else begin
      prev_ref <= ref_o;
      since_step <= stepped ? '0 : ((since_step < TICK_CYC) ? since_step + 1 : since_step);
    end
  end
  chk_rdata_quiet: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000)
    else $error("read data not zero outside read cycle");
  chk_unmapped_zero: assert property (reg_rd_i && reg_addr_i > 8'h34 |=> reg_rdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_idle_output: assert property (state_o == RLIG_IDLE |-> ref_o == 16'h0000 && !drive_en_o)
    else $error("idle with reference or drive");
  chk_drive_active: assert property (state_o != RLIG_IDLE |-> drive_en_o)
    else $error("drive off outside idle");
  chk_start_zero: assert property ((state_o == RLIG_IDLE ##1 state_o == RLIG_RUN) |-> ref_o == 16'h0000)
    else $error("ramp not starting from zero");
  chk_tick_spacing: assert property (stepped |-> since_step >= TICK_CYC - 1)
    else $error("reference stepped twice within one tick");
  chk_run_refused: assert property ((state_o == RLIG_IDLE ##1 ilk_sat_o != 4'hF) |-> state_o == RLIG_IDLE)
    else $error("run started with interlock open");
  chk_ilk_stop: assert property ((state_o == RLIG_RUN ##1 ilk_sat_o != 4'hF) |-> state_o != RLIG_RUN)
    else $error("run kept with interlock open");
  chk_warn_led: assert property (warn_o |-> led_o)
    else $error("warning without indicator flash");
  chk_warn_quiet: assert property (ilk_sat_o == 4'hF [*3] |-> !$past(warn_o))
    else $error("warning with all interlocks satisfied");
  cov_ramp_stop: cover property (state_o == RLIG_DECEL ##1 state_o == RLIG_IDLE);
  cov_coast: cover property (state_o == RLIG_RUN ##1 state_o == RLIG_IDLE);
  cov_warn: cover property (warn_o);
endmodule // rlig_checker
bind rlig_core rlig_checker #(.TICK_CYC(TICK_CYC)) i_rlig_checker (.core_clk_i(core_clk_i),
  .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .drive_en_o(drive_en_o), .ref_o(ref_o), .state_o(state_o), .ilk_sat_o(ilk_sat_o), .warn_o(warn_o),
  .led_o(led_o));
`default_nettype wire

// ---- test/rlig_motor_model.sv ----
// Behavioural motor stage and interlock switch bank facing the gate.
`timescale 1ns/1ps
`default_nettype none
module rlig_motor_model (
  // Clock
  input wire logic clk_i,
  // Gate outputs
  input wire logic drive_en_i,
  input wire rlig_pkg::rlig_ref_t ref_i,
  // Bench commands
  input wire logic [5:0] switch_i,
  input wire logic overload_i,
  input wire logic slow_i,
  // Towards the gate
  output logic [5:0] logic_input_o,
  output logic [15:0] current_o
);
  import rlig_pkg::*;
  logic [15:0] load_now;
  logic [15:0] load_lag;
  // An idle stage draws nothing; the overload command stands in for a jammed pump.
  assign load_now = !drive_en_i ? 16'h0000 : (overload_i ? 16'h03E8 : {1'b0, ref_i[15:1]});
  assign logic_input_o = switch_i;
  always_ff @(posedge clk_i) begin
    load_lag <= load_now;
  end
  // A slow sensor reports one cycle late.
  assign current_o = slow_i ? load_lag : load_now;
endmodule // rlig_motor_model
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking bench for the ramp, limit and interlock gate.
`timescale 1ns/1ps
`default_nettype none
`include "rlig_defs.svh"
module tb_top;
  import rlig_pkg::*;
  localparam int unsigned TICK = 20;
  typedef struct packed { logic [7:0] addr; logic [31:0] exp; } rlig_row_s;
  logic core_clk, reset_n, reg_wr, reg_rd, drive_en, cur_lim, warn, led, irq, overload, slow;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, rdata, v;
  logic [5:0] sw, lin;
  logic [15:0] current;
  logic [3:0] ilk_sat;
  rlig_ref_t ref_out, torque_ref, torque_out;
  rlig_state_e state;
  int failures, n_tests, cycles;
  rlig_row_s rows [13] = '{'{`RLIG_A_CTRL, 32'h0000_0000}, '{`RLIG_A_STATUS, 32'h0000_000F},
    '{`RLIG_A_TARGET, 32'h0000_1388}, '{`RLIG_A_ACC_TIME, 32'h0000_7530}, '{`RLIG_A_DEC_TIME, 32'h0000_7530},
    '{`RLIG_A_FREQ_LIM, 32'hFFFF_0000}, '{`RLIG_A_SPEED_LIM, 32'hFFFF_0000}, '{`RLIG_A_TORQ_LIM, 32'hFFFF_0000},
    '{`RLIG_A_CUR_MAX, 32'h0000_0000}, '{`RLIG_A_ILK_CFG, 32'h0000_0000}, '{`RLIG_A_REF_OUT, 32'h0000_0000},
    '{8'h3C, 32'h0000_0000}, '{8'h80, 32'h0000_0000}};
  rlig_core #(.TICK_CYC(TICK)) i_rlig_core (.core_clk_i(core_clk), .reset_n_i(reset_n), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .torque_ref_i(torque_ref),
    .current_i(current), .logic_input_i(lin), .drive_en_o(drive_en), .ref_o(ref_out), .torque_ref_o(torque_out),
    .cur_lim_o(cur_lim), .state_o(state), .ilk_sat_o(ilk_sat), .warn_o(warn), .led_o(led), .irq_o(irq));
  rlig_motor_model i_rlig_motor_model (.clk_i(core_clk), .drive_en_i(drive_en), .ref_i(ref_out), .switch_i(sw),
    .overload_i(overload), .slow_i(slow), .logic_input_o(lin), .current_o(current));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // The ceiling is about twice the length of the whole sequence.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("Error run length expected below %0d seen %0d", 20000, cycles);
      stop_test();
    end
  end
  task automatic ck(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wref(input rlig_ref_t old);
    for (int i = 0; i < 80 && ref_out === old; i++) @(posedge core_clk);
    #1;
  endtask
  initial begin
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    torque_ref = 16'h1234;
    sw = 6'b00_0000;
    overload = 1'b0;
    slow = 1'b1;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    wr_reg(`RLIG_A_STATUS, 32'hFFFF_FFFF);
    wr_reg(`RLIG_A_REF_OUT, 32'hFFFF_FFFF);
    foreach (rows[i]) begin
      rd_reg(rows[i].addr, v);
      ck($sformatf("register %h", rows[i].addr), v, rows[i].exp);
    end
    ck("torque", 32'(torque_out), 32'h0000_1234);
    wr_reg(`RLIG_A_TORQ_LIM, 32'h1000_0000);
    wt(1);
    ck("torque clamp", 32'(torque_out), 32'h0000_1000);
    $display("test registers done");
    wr_reg(`RLIG_A_TARGET, 32'h0000_0064);
    wr_reg(`RLIG_A_ACC_TIME, 32'h0000_000A);
    wr_reg(`RLIG_A_DEC_TIME, 32'h0000_0005);
    wr_reg(`RLIG_A_CMD_REF, 32'h0000_0064);
    wt(150);
    wr_reg(`RLIG_A_CTRL, 32'h0000_0001);
    wref(16'h0000);
    ck("first step", 32'(ref_out), 32'h0000_000A);
    wt(11 * TICK);
    ck("ramp top", 32'(ref_out), 32'h0000_0064);
    wr_reg(`RLIG_A_CMD_REF, 32'h0000_001E);
    wref(16'h0064);
    ck("down step", 32'(ref_out), 32'h0000_0050);
    wt(5 * TICK);
    ck("down end", 32'(ref_out), 32'h0000_001E);
    wr_reg(`RLIG_A_FREQ_LIM, 32'h0032_0014);
    wr_reg(`RLIG_A_CMD_REF, 32'h0000_0064);
    wt(5 * TICK);
    ck("max clamp", 32'(ref_out), 32'h0000_0032);
    wr_reg(`RLIG_A_CUR_MAX, 32'h0000_0032);
    @(posedge core_clk);
    overload <= 1'b1;
    wt(4);
    ck("current limit", 32'(cur_lim), 32'h0000_0001);
    wt(4 * TICK);
    ck("current fold", 32'(ref_out), 32'h0000_0014);
    rd_reg(`RLIG_A_IRQ_STAT, v);
    ck("overcurrent event", 32'(v[1]), 32'h0000_0001);
    @(posedge core_clk);
    overload <= 1'b0;
    wr_reg(`RLIG_A_CUR_MAX, 32'h0000_0000);
    wr_reg(`RLIG_A_CTRL, 32'h0000_0003);
    wt(10 * TICK);
    ck("vector limits", 32'(ref_out), 32'h0000_0064);
    wr_reg(`RLIG_A_CTRL, 32'h0000_0002);
    wt(2);
    ck("ramp stop", 32'(state), 32'(RLIG_DECEL));
    wt(7 * TICK);
    ck("stopped", 32'({state, ref_out}), 32'({RLIG_IDLE, 16'h0000}));
    wr_reg(`RLIG_A_CTRL, 32'h0000_0001);
    wref(16'h0000);
    wr_reg(`RLIG_A_CTRL, 32'h0000_0004);
    wt(1);
    ck("coast", 32'({drive_en, state, ref_out}), 32'({1'b0, RLIG_IDLE, 16'h0000}));
    $display("test ramps done");
    @(posedge core_clk);
    sw <= 6'b00_0100;
    wr_reg(`RLIG_A_ILK_CFG, 32'h0000_151A);
    wt(2);
    ck("interlocks met", 32'(ilk_sat), 32'h0000_000F);
    wr_reg(`RLIG_A_CTRL, 32'h0000_0009);
    wt(2);
    ck("run", 32'(state), 32'(RLIG_RUN));
    @(posedge core_clk);
    sw <= 6'b00_0000;
    wt(3);
    ck("interlock coast", 32'({ilk_sat, state}), 32'({4'hE, RLIG_IDLE}));
    wr_reg(`RLIG_A_IRQ_MASK, 32'h0000_0001);
    wt(1);
    ck("irq raised", 32'(irq), 32'h0000_0001);
    wr_reg(`RLIG_A_IRQ_MASK, 32'h0000_0000);
    wt(1);
    ck("irq masked", 32'(irq), 32'h0000_0000);
    wr_reg(`RLIG_A_IRQ_MASK, 32'h0000_0001);
    wr_reg(`RLIG_A_IRQ_STAT, 32'h0000_0001);
    wt(1);
    ck("irq cleared", 32'(irq), 32'h0000_0000);
    wt(TICK);
    ck("run refused", 32'(state), 32'(RLIG_IDLE));
    rd_reg(`RLIG_A_STATUS, v);
    ck("status warn", v & 32'h0000_003F, 32'h0000_001E);
    wr_reg(`RLIG_A_CTRL, 32'h0000_0010);
    rd_reg(`RLIG_A_STATUS, v);
    ck("warn needs run", {v[31:1] & 31'h0000_001F, warn}, 32'h0000_000E);
    wr_reg(`RLIG_A_CTRL, 32'h0000_0000);
    rd_reg(`RLIG_A_STATUS, v);
    ck("warn always", v & 32'h0000_003F, 32'h0000_001E);
    // The flash half period is long, so wait for each phase instead of counting to it.
    for (int i = 0; i < 6000 && warn !== 1'b1; i++) @(posedge core_clk);
    #1;
    ck("flash on", 32'({warn, led}), 32'h0000_0003);
    for (int i = 0; i < 6000 && led !== 1'b0; i++) @(posedge core_clk);
    #1;
    ck("flash off", 32'({warn, led}), 32'h0000_0000);
    @(posedge core_clk);
    sw <= 6'b10_0000;
    wt(2);
    ck("low polarity", 32'(ilk_sat), 32'h0000_000C);
    @(posedge core_clk);
    sw <= 6'b00_0100;
    wr_reg(`RLIG_A_CTRL, 32'h0000_0001);
    wref(16'h0000);
    @(posedge core_clk);
    sw <= 6'b00_0000;
    wt(3);
    ck("interlock ramp", 32'(state), 32'(RLIG_DECEL));
    $display("test interlocks done");
    @(posedge core_clk);
    reset_n <= 1'b0;
    #1;
    ck("reset outputs", 32'({drive_en, led, ilk_sat, ref_out}), 32'({1'b0, 1'b1, 4'hF, 16'h0000}));
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    wt(2);
    ck("reset state", 32'({state, ref_out, ilk_sat}), 32'({RLIG_IDLE, 16'h0000, 4'hF}));
    rd_reg(`RLIG_A_ILK_CFG, v);
    ck("reset interlock config", v, 32'h0000_0000);
    rd_reg(`RLIG_A_IRQ_STAT, v);
    ck("reset events", v, 32'h0000_0000);
    $display("test reset done");
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
